// file: hw/spp_pkg.sv
// constants, types and register map of the two-port serial protocol buffer
// assumes a 125 MHz apb clock and 8n1 framing on both lines
package spp_pkg;

	localparam int unsigned CLK_HZ    = 125_000_000;
	localparam int unsigned BAUD_DEF  = 38_400;
	localparam int unsigned BAUD_HALT = 9_600;
	localparam logic [13:0] DIV_DEF   = 14'(CLK_HZ / BAUD_DEF);
	localparam logic [13:0] DIV_HALT  = 14'(CLK_HZ / BAUD_HALT);

	// idle timeout of a locked protocol mode
	localparam int unsigned TMO_S   = 10;
	localparam logic [30:0] TMO_CYC = 31'(longint'(TMO_S) * CLK_HZ);

	// idle bit times that close a binary frame (3.5 characters)
	localparam logic [20:0] RTU_GAP_BITS = 21'h23;

	localparam int unsigned NPORT    = 2;
	localparam int unsigned MDROP    = 1;
	localparam logic [8:0]  BUF_FULL = 9'h100;
	localparam logic [3:0]  BIT_STOP = 4'h9;

	localparam logic [7:0]  CHR_CR    = 8'h0d;
	localparam logic [7:0]  CHR_LF    = 8'h0a;
	localparam logic [7:0]  CHR_COLON = 8'h3a;
	localparam logic [7:0]  CHR_AT    = 8'h40;
	localparam logic [15:0] CRC_INIT  = 16'hffff;
	localparam logic [15:0] CRC_POLY  = 16'ha001;
	localparam logic [31:0] RD_EMPTY  = 32'hffffffff;

	// per-port register block, port select on paddr[PORT_BIT]
	localparam int unsigned PORT_BIT   = 5;
	localparam logic [4:0]  REG_RXCHAR = 5'h00;
	localparam logic [4:0]  REG_RXSTR  = 5'h04;
	localparam logic [4:0]  REG_TXBUF  = 5'h08;
	localparam logic [4:0]  REG_TXDIR  = 5'h0c;
	localparam logic [4:0]  REG_CTRL   = 5'h10;
	localparam logic [4:0]  REG_STAT   = 5'h14;
	localparam logic [4:0]  REG_CNT    = 5'h18;

	// ctrl protocol codes
	localparam logic [2:0] PROT_AUTO   = 3'h0;
	localparam logic [2:0] PROT_NONE   = 3'h1;
	localparam logic [2:0] PROT_NATIVE = 3'h2;
	localparam logic [2:0] PROT_ASCII  = 3'h3;
	localparam logic [2:0] PROT_RTU    = 3'h4;

	// status and counter field positions
	localparam int unsigned ST_MODE  = 0;
	localparam int unsigned ST_FIXED = 3;
	localparam int unsigned ST_RXN   = 4;
	localparam int unsigned ST_TXN   = 13;
	localparam int unsigned ST_DPEND = 22;
	localparam int unsigned ST_CRN   = 23;
	localparam int unsigned CNT_OK   = 0;
	localparam int unsigned CNT_ERR  = 8;
	localparam int unsigned CNT_REJ  = 16;

	typedef enum logic [2:0] {
		MODE_AUTO, MODE_NONE, MODE_NATIVE, MODE_ASCII, MODE_RTU
	} spp_mode_t;

	typedef enum logic [1:0] {
		FRM_IDLE, FRM_NATIVE, FRM_ASCII, FRM_RTU
	} spp_frm_t;

	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} spp_apb_req_t;

	typedef struct packed {
		spp_mode_t        mode;
		logic             fixed;
		spp_frm_t         frm;
		logic [15:0]      acc;
		logic [7:0]       x1;
		logic [7:0]       x2;
		logic [7:0]       b0;
		logic [7:0]       b1;
		logic [3:0]       nib;
		logic             half;
		logic [20:0]      gap;
		logic [30:0]      tmo;
		logic [7:0]       okc;
		logic [7:0]       errc;
		logic [7:0]       rejc;
		logic [13:0]      div;
		logic             r_act;
		logic [13:0]      r_cnt;
		logic [3:0]       rbit;
		logic [7:0]       r_sh;
		logic [255:0][7:0] rxm;
		logic [7:0]       rw;
		logic [7:0]       rr;
		logic [8:0]       rn;
		logic [8:0]       crn;
		logic [255:0][7:0] txm;
		logic [7:0]       tw;
		logic [7:0]       tr;
		logic [8:0]       tn;
		logic             dpend;
		logic [7:0]       dbyte;
		logic             t_act;
		logic [13:0]      t_cnt;
		logic [3:0]       tbit;
		logic [8:0]       t_sh;
		logic             txd;
	} spp_port_t;

	typedef struct packed {
		spp_port_t [NPORT-1:0] p;
		logic [31:0]           rdata;
		logic                  slverr;
		logic                  pop;
		logic                  strapped;
	} spp_state_t;

endpackage

// file: hw/spp_top.sv
// two-port serial protocol buffer with apb register access
// assumes rxd and the halt switch are synchronous to pclk
// Functional notes
// - both ports start in automatic detection
// - recognised valid frame locks port to protocol
// - each protocol's check value verifies every frame
// - locked port rejects frames of other protocols
// - ten idle seconds return locked port to auto
// - each port keeps its own mode
// - software may select buffer-only no-protocol mode
// - software may fix one protocol permanently
// - every received byte enters 256-byte ring
// - handled command bytes stay in receive queue
// - full ring overwrites oldest byte, never stalls
// - char read pops one byte, empty gives -1
// - string read only when a CR is buffered
// - buffered writes fill separate 256-byte transmit ring
// - multidrop driver enabled when sending starts
// - driver released right after final stop bit
// - direct byte bypasses ring, same driver control
// - halt switch at power-up gives first port 9600
// - power-up line format is 38400 8n1
module spp_top #(
	parameter logic [30:0] TMO_CYCLES = spp_pkg::TMO_CYC
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire spp_pkg::spp_apb_req_t apb_req,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [1:0]            rxd,
	output logic [1:0]                 txd,
	output logic                       rs485_de,
	output logic                       rs485_re_n,
	input  wire logic                  program_halt_switch
);
	import spp_pkg::*;

	spp_state_t st_q;
	spp_state_t st_d;
	logic       setup;
	logic       access;
	logic       sel;
	logic [4:0] off;
	logic       map_ok;
	logic       stall;

	function automatic logic [15:0] crc_upd(logic [15:0] c, logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int k = 0; k < 8; k++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic [3:0] hexv(logic [7:0] c);
		logic [3:0] v;
		v = c[3:0];
		if (c[6]) begin
			v = 4'(c[3:0] + 4'h9);
		end
		return v;
	endfunction

	function automatic spp_mode_t frm_mode(spp_frm_t f);
		spp_mode_t m;
		m = MODE_RTU;
		if (f == FRM_NATIVE) begin
			m = MODE_NATIVE;
		end else if (f == FRM_ASCII) begin
			m = MODE_ASCII;
		end
		return m;
	endfunction

	function automatic spp_port_t step(
		spp_port_t   p,
		logic        rx,
		logic        ctl_we,
		logic        tx_we,
		logic        dir_we,
		logic [7:0]  wd,
		logic        pop,
		logic [30:0] tmo_lim
	);
		spp_port_t  q;
		logic [7:0] b;
		logic [7:0] tb;
		logic       got;
		logic       done;
		logic       good;
		spp_frm_t   k;
		q = p;
		b = '0;
		tb = '0;
		got = 1'b0;
		done = 1'b0;
		good = 1'b0;
		k = q.frm;
		// pop before push so a full ring never loses the popped byte
		if (pop && q.rn != '0) begin
			if (q.rxm[q.rr] == CHR_CR) begin
				q.crn = q.crn - 9'h001;
			end
			q.rr = q.rr + 8'h01;
			q.rn = q.rn - 9'h001;
		end
		// receiver, sampled mid-bit
		if (!q.r_act) begin
			if (!rx) begin
				q.r_act = 1'b1;
				q.r_cnt = {1'b0, q.div[13:1]};
				q.rbit = '0;
			end
		end else if (q.r_cnt != '0) begin
			q.r_cnt = q.r_cnt - 14'h0001;
		end else begin
			q.r_cnt = q.div - 14'h0001;
			if (q.rbit == '0 && rx) begin
				q.r_act = 1'b0;
			end else if (q.rbit == BIT_STOP) begin
				q.r_act = 1'b0;
				got = rx;
				b = q.r_sh;
			end else begin
				if (q.rbit != '0) begin
					q.r_sh = {rx, q.r_sh[7:1]};
				end
				q.rbit = q.rbit + 4'h1;
			end
		end
		if (got) begin
			if (q.rn == BUF_FULL) begin
				if (q.rxm[q.rr] == CHR_CR) begin
					q.crn = q.crn - 9'h001;
				end
				q.rr = q.rr + 8'h01;
			end else begin
				q.rn = q.rn + 9'h001;
			end
			q.rxm[q.rw] = b;
			q.rw = q.rw + 8'h01;
			if (b == CHR_CR) begin
				q.crn = q.crn + 9'h001;
			end
		end
		if (got || q.r_act) begin
			q.gap = '0;
		end else if (q.gap != '1) begin
			q.gap = q.gap + 21'h000001;
		end
		// frame parser, skipped entirely in no-protocol mode
		if (got && q.mode != MODE_NONE) begin
			unique case (q.frm)
				FRM_IDLE: begin
					if (b == CHR_COLON) begin
						q.frm = FRM_ASCII;
						q.acc = '0;
						q.half = 1'b0;
					end else if (b == CHR_AT) begin
						q.frm = FRM_NATIVE;
						q.acc = {8'h00, b};
						q.x1 = '0;
						q.x2 = '0;
					end else if (b != CHR_LF) begin
						q.frm = FRM_RTU;
						q.acc = crc_upd(CRC_INIT, b);
					end
				end
				FRM_ASCII: begin
					if (b == CHR_CR) begin
						done = 1'b1;
						good = (q.acc[7:0] == 8'h00);
					end else begin
						if (q.half) begin
							q.acc[7:0] = q.acc[7:0] + {q.nib, hexv(b)};
						end else begin
							q.nib = hexv(b);
						end
						q.half = !q.half;
					end
				end
				FRM_NATIVE: begin
					if (b == CHR_CR) begin
						done = 1'b1;
						good = (q.x2 == {hexv(q.b1), hexv(q.b0)});
					end else begin
						q.x2 = q.x1;
						q.x1 = q.acc[7:0];
						q.acc[7:0] = q.acc[7:0] ^ b;
						q.b1 = q.b0;
						q.b0 = b;
					end
				end
				FRM_RTU: begin
					q.acc = crc_upd(q.acc, b);
				end
			endcase
		end
		// binary frames end on line silence
		if (q.frm == FRM_RTU && !got && q.gap >= 21'(q.div) * RTU_GAP_BITS) begin
			done = 1'b1;
			good = (q.acc == 16'h0000);
		end
		if (done) begin
			k = q.frm;
			q.frm = FRM_IDLE;
			if (q.mode != MODE_AUTO && q.mode != frm_mode(k)) begin
				q.rejc = q.rejc + 8'h01;
			end else if (good) begin
				q.okc = q.okc + 8'h01;
				q.tmo = '0;
				if (q.mode == MODE_AUTO) begin
					q.mode = frm_mode(k);
				end
			end else begin
				q.errc = q.errc + 8'h01;
			end
		end
		if (q.mode != MODE_AUTO && !q.fixed) begin
			if (q.tmo >= tmo_lim) begin
				q.mode = MODE_AUTO;
				q.tmo = '0;
			end else begin
				q.tmo = q.tmo + 31'h00000001;
			end
		end
		if (ctl_we && wd[2:0] <= PROT_RTU) begin
			q.frm = FRM_IDLE;
			q.tmo = '0;
			q.fixed = (wd[2:0] != PROT_AUTO);
			unique case (wd[2:0])
				PROT_NONE:   q.mode = MODE_NONE;
				PROT_NATIVE: q.mode = MODE_NATIVE;
				PROT_ASCII:  q.mode = MODE_ASCII;
				PROT_RTU:    q.mode = MODE_RTU;
				default:     q.mode = MODE_AUTO;
			endcase
		end
		if (tx_we) begin
			q.txm[q.tw] = wd;
			q.tw = q.tw + 8'h01;
			q.tn = q.tn + 9'h001;
		end
		if (dir_we) begin
			q.dpend = 1'b1;
			q.dbyte = wd;
		end
		// transmitter; t_act spans start bit to end of stop bit
		if (q.t_act) begin
			if (q.t_cnt != '0) begin
				q.t_cnt = q.t_cnt - 14'h0001;
			end else if (q.tbit == BIT_STOP) begin
				q.t_act = 1'b0;
			end else begin
				q.txd = q.t_sh[0];
				q.t_sh = {1'b1, q.t_sh[8:1]};
				q.tbit = q.tbit + 4'h1;
				q.t_cnt = q.div - 14'h0001;
			end
		end
		if (!q.t_act && (q.dpend || q.tn != '0)) begin
			if (q.dpend) begin
				tb = q.dbyte;
				q.dpend = 1'b0;
			end else begin
				tb = q.txm[q.tr];
				q.tr = q.tr + 8'h01;
				q.tn = q.tn - 9'h001;
			end
			q.t_sh = {1'b1, tb};
			q.txd = 1'b0;
			q.tbit = '0;
			q.t_cnt = q.div - 14'h0001;
			q.t_act = 1'b1;
		end
		return q;
	endfunction

	assign setup = apb_req.psel & ~apb_req.penable;
	assign access = apb_req.psel & apb_req.penable & pready;
	assign sel = apb_req.paddr[PORT_BIT];
	assign off = apb_req.paddr[4:0];
	assign map_ok = (apb_req.paddr[7:6] == 2'h0) && (off <= REG_CNT)
		&& (off[1:0] == 2'h0);
	// hold the access phase while the target slot is occupied
	assign stall = apb_req.psel & apb_req.pwrite & map_ok
		& (((off == REG_TXBUF) & (st_q.p[sel].tn == BUF_FULL))
		| ((off == REG_TXDIR) & st_q.p[sel].dpend));
	assign pready = ~stall;
	assign prdata = st_q.rdata;
	assign pslverr = st_q.slverr;
	assign rs485_de = st_q.p[MDROP].t_act;
	assign rs485_re_n = st_q.p[MDROP].t_act;
	assign txd = {st_q.p[1].txd, st_q.p[0].txd};

	always_comb begin
		st_d = st_q;
		// read data and pop decision are frozen in the setup cycle
		if (setup) begin
			st_d.slverr = !map_ok;
			st_d.pop = 1'b0;
			st_d.rdata = '0;
			if (map_ok && !apb_req.pwrite) begin
				unique case (off)
					REG_RXCHAR: begin
						st_d.rdata = RD_EMPTY;
						if (st_q.p[sel].rn != '0) begin
							st_d.rdata = {24'h000000, st_q.p[sel].rxm[st_q.p[sel].rr]};
							st_d.pop = 1'b1;
						end
					end
					REG_RXSTR: begin
						st_d.rdata = RD_EMPTY;
						if (st_q.p[sel].crn != '0) begin
							st_d.rdata = {24'h000000, st_q.p[sel].rxm[st_q.p[sel].rr]};
							st_d.pop = 1'b1;
						end
					end
					REG_CTRL: begin
						st_d.rdata[ST_FIXED] = st_q.p[sel].fixed;
						st_d.rdata[ST_MODE +: 3] = st_q.p[sel].mode;
					end
					REG_STAT: begin
						st_d.rdata[ST_MODE +: 3] = st_q.p[sel].mode;
						st_d.rdata[ST_FIXED] = st_q.p[sel].fixed;
						st_d.rdata[ST_RXN +: 9] = st_q.p[sel].rn;
						st_d.rdata[ST_TXN +: 9] = st_q.p[sel].tn;
						st_d.rdata[ST_DPEND] = st_q.p[sel].dpend;
						st_d.rdata[ST_CRN +: 9] = st_q.p[sel].crn;
					end
					REG_CNT: begin
						st_d.rdata[CNT_OK +: 8] = st_q.p[sel].okc;
						st_d.rdata[CNT_ERR +: 8] = st_q.p[sel].errc;
						st_d.rdata[CNT_REJ +: 8] = st_q.p[sel].rejc;
					end
					default: st_d.rdata = '0;
				endcase
			end
		end
		if (access) begin
			st_d.pop = 1'b0;
		end
		for (int i = 0; i < NPORT; i++) begin
			st_d.p[i] = step(st_q.p[i], rxd[i],
				access & apb_req.pwrite & map_ok & (sel == i[0])
					& (off == REG_CTRL),
				access & apb_req.pwrite & map_ok & (sel == i[0])
					& (off == REG_TXBUF),
				access & apb_req.pwrite & map_ok & (sel == i[0])
					& (off == REG_TXDIR),
				apb_req.pwdata[7:0],
				access & st_q.pop & (sel == i[0]),
				TMO_CYCLES - 31'h00000001);
		end
		// halt switch is caught once, on the first edge after reset
		if (!st_q.strapped) begin
			st_d.strapped = 1'b1;
			if (program_halt_switch) begin
				st_d.p[0].div = DIV_HALT;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
			for (int i = 0; i < NPORT; i++) begin
				st_q.p[i].div <= DIV_DEF;
				st_q.p[i].txd <= 1'b1;
			end
		end else begin
			st_q <= st_d;
		end
	end

endmodule

// file: verif/spp_chk.sv
// concurrent checks on the serial protocol buffer top ports
// assumes one pclk domain and the default bit period on port1
module spp_chk #(
	parameter logic [30:0] TMO_CYCLES = spp_pkg::TMO_CYC
) (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire spp_pkg::spp_apb_req_t apb_req,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic [1:0]            rxd,
	input wire logic [1:0]            txd,
	input wire logic                  rs485_de,
	input wire logic                  rs485_re_n,
	input wire logic                  program_halt_switch
);
	timeunit 1ns;
	timeprecision 1ps;
	import spp_pkg::*;
	localparam logic [15:0] BIT_CYC   = 16'(DIV_DEF);
	localparam logic [15:0] BURST_MAX = 16'(10 * DIV_DEF);
	localparam logic [7:0]  A_TX0     = {3'h0, REG_TXBUF};
	localparam logic [7:0]  A_DIR1    = {3'h1, REG_TXDIR};
	logic        acc;
	logic [15:0] hi_q;
	logic [8:0]  wr0_q;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign acc = apb_req.psel && apb_req.penable;
	// high time of the driven line; bounds how long the driver may linger
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_q <= 16'h0;
			wr0_q <= 9'h0;
		end else begin
			hi_q <= (rs485_de && txd[1]) ? hi_q + 16'h1 : 16'h0;
			if (acc && pready && apb_req.pwrite && apb_req.paddr == A_TX0
				&& !wr0_q[8])
				wr0_q <= wr0_q + 9'h1;
		end
	end
	property p_re_follows_de;
		rs485_re_n == rs485_de;
	endproperty
	a_re_follows_de: assert property (p_re_follows_de)
		else $error("receiver enable not opposite to driving");
	property p_de_rise_start;
		$rose(rs485_de) |-> !txd[1];
	endproperty
	a_de_rise_start: assert property (p_de_rise_start)
		else $error("driver enabled without start bit");
	property p_idle_high;
		!rs485_de |-> txd[1];
	endproperty
	a_idle_high: assert property (p_idle_high)
		else $error("line not idle while driver off");
	property p_fall_after_stop;
		$fell(rs485_de) |-> hi_q >= BIT_CYC - 16'h1;
	endproperty
	a_fall_after_stop: assert property (p_fall_after_stop)
		else $error("driver released before stop bit ended");
	property p_release_prompt;
		rs485_de |-> hi_q <= BURST_MAX;
	endproperty
	a_release_prompt: assert property (p_release_prompt)
		else $error("driver held after last stop bit");
	property p_direct_kick;
		acc && pready && apb_req.pwrite && apb_req.paddr == A_DIR1
			&& !rs485_de |-> ##[1:2] (rs485_de && !txd[1]);
	endproperty
	a_direct_kick: assert property (p_direct_kick)
		else $error("direct byte did not start promptly");
	property p_read_no_wait;
		acc && !apb_req.pwrite |-> pready;
	endproperty
	a_read_no_wait: assert property (p_read_no_wait)
		else $error("read access stalled");
	property p_stall_when_full;
		acc && apb_req.pwrite && apb_req.paddr == A_TX0 && !pready
			|-> wr0_q[8];
	endproperty
	a_stall_when_full: assert property (p_stall_when_full)
		else $error("transmit write stalled before ring filled");
endmodule

// file: verif/spp_host.sv
// host model on one serial line: sends bytes, collects bytes
// assumes the device runs the default bit period, 8n1
module spp_host (
	input wire logic clk,
	output logic     rxd,
	input wire logic txd
);
	timeunit 1ns;
	timeprecision 1ps;
	import spp_pkg::*;
	logic [7:0]  got[$];
	int unsigned n_sent = 0;
	initial rxd = 1'b1;
	// direct host at the default rate; a modem stays at 9600
	// lsb first, stop high, then line rests high
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (DIV_DEF) @(posedge clk);
		end
		n_sent++;
	endtask
	// mid-bit sampling; a low stop bit drops the byte
	always begin : rx
		logic [7:0] b;
		@(negedge txd);
		repeat (DIV_DEF / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (DIV_DEF) @(posedge clk);
			b[i] = txd;
		end
		repeat (DIV_DEF) @(posedge clk);
		if (txd === 1'b1)
			got.push_back(b);
	end
endmodule

// file: verif/spp_top_test.sv
// self-checking bench for the two-port serial protocol buffer
// assumes halt switch low, bar the last reset; lines then run default
module spp_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import spp_pkg::*;
	logic         pclk = 1'b0;
	logic         presetn;
	spp_apb_req_t req;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	wire  [1:0]   rxd_w;
	logic [1:0]   txd;
	logic         de;
	logic         re_n;
	logic         err_s;
	logic         halt;
	int           n_fail = 0;
	int           checks = 0;
	spp_top #(.TMO_CYCLES(31'h7d0)) dut (
		.pclk(pclk),
		.presetn(presetn),
		.apb_req(req),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.rxd(rxd_w),
		.txd(txd),
		.rs485_de(de),
		.rs485_re_n(re_n),
		.program_halt_switch(halt)
	);
	spp_host h0 (.clk(pclk), .rxd(rxd_w[0]), .txd(txd[0]));
	spp_host h1 (.clk(pclk), .rxd(rxd_w[1]), .txd(txd[1]));
	always #4 pclk = ~pclk;
	task automatic summarize;
		$display("checks %0d fails %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// values read just after a rise are those that rise sampled
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output int w);
		w = -1;
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			w++;
		end while (pready !== 1'b1);
		r = prdata;
		err_s = pslverr;
		req <= '0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hffffffff);
		logic [31:0] r;
		int w;
		apb(1'b0, a, 32'h0, r, w);
		chk(r & m, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		int w;
		apb(1'b1, a, d, r, w);
	endtask
	function automatic logic [7:0] ad(input int p, input logic [4:0] o);
		return {2'b00, p[0], o};
	endfunction
	initial begin
		logic [31:0] r;
		int w;
		int stl;
		int n;
		req = '0;
		halt = 1'b0;
		presetn = 1'b0;
		stl = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		for (int p = 0; p < 2; p++) begin
			rd(ad(p, REG_STAT), 32'h0);
			rd(ad(p, REG_RXCHAR), RD_EMPTY);
			rd(ad(p, REG_RXSTR), RD_EMPTY);
		end
		apb(1'b0, 8'h1c, 32'h0, r, w);
		chk(32'(err_s), 32'h1);
		for (int c = 1; c < 5; c++) begin
			wr(ad(0, REG_CTRL), 32'(c));
			rd(ad(0, REG_STAT), 32'(c) | 32'h8, 32'hf);
			rd(ad(1, REG_STAT), 32'h0, 32'hf);
		end
		wr(ad(0, REG_CTRL), 32'h5);
		rd(ad(0, REG_STAT), 32'hc, 32'hf);
		wr(ad(0, REG_CTRL), {29'h0, PROT_AUTO});
		rd(ad(0, REG_STAT), 32'h0, 32'hf);
		wr(ad(0, REG_CTRL), {29'h0, PROT_NONE});
		wr(ad(1, REG_TXDIR), 32'ha5);
		wr(ad(1, REG_TXBUF), 32'h5a);
		fork
			begin
				h0.send(8'h41);
				h0.send(CHR_CR);
			end
			begin
				h1.send(CHR_COLON);
				h1.send(CHR_CR);
			end
		join_none
		// one more than ring plus shifter hold, so a stall must show
		for (int i = 0; i < 258; i++) begin
			apb(1'b1, ad(0, REG_TXBUF), {24'h0, 8'(i)}, r, w);
			if (w > 0)
				stl = 1;
		end
		chk(32'(stl), 32'h1);
		wait (h0.n_sent >= 1);
		@(posedge pclk);
		rd(ad(0, REG_RXSTR), RD_EMPTY);
		rd(ad(0, REG_STAT), 32'h19, 32'h1fff);
		wait (h0.n_sent >= 2);
		@(posedge pclk);
		// empty ascii frame locks port1; timeout not yet run out, about 1630 of its 2000 cycles gone
		rd(ad(1, REG_STAT), 32'h00800023);
		rd(ad(1, REG_CNT), 32'h1);
		rd(ad(0, REG_CNT), 32'h0);
		rd(ad(0, REG_RXCHAR), 32'h41);
		rd(ad(0, REG_STAT), 32'h10, 32'h1ff0);
		rd(ad(0, REG_RXSTR), {24'h0, CHR_CR});
		rd(ad(0, REG_RXSTR), RD_EMPTY);
		wait (h1.got.size() == 2);
		chk({24'h0, h1.got[0]}, 32'ha5);
		chk({24'h0, h1.got[1]}, 32'h5a);
		repeat (DIV_DEF) @(posedge pclk);
		chk(32'(de), 32'h0);
		rd(ad(1, REG_STAT), 32'h00800020);
		rd(ad(1, REG_RXCHAR), {24'h0, CHR_COLON});
		rd(ad(1, REG_RXSTR), {24'h0, CHR_CR});
		rd(ad(1, REG_RXCHAR), RD_EMPTY);
		chk(32'(h0.got.size() > 1), 32'h1);
		chk({24'h0, h0.got[0]}, 32'h0);
		chk({24'h0, h0.got[1]}, 32'h1);
		// second reset with the halt switch on: slow first port
		halt <= 1'b1;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		wr(ad(0, REG_TXDIR), 32'hff);
		n = 0;
		while (txd[0] !== 1'b1) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(n), 32'(DIV_HALT));
		rd(ad(1, REG_STAT), 32'h0);
		summarize();
	end
	// run needs about 82k cycles, mostly byte times
	initial begin
		repeat (90000) @(posedge pclk);
		n_fail++;
		$display("[ERR] %0t watchdog expired", $time);
		summarize();
	end
endmodule
bind spp_top spp_chk #(.TMO_CYCLES(TMO_CYCLES)) u_chk (
	.pclk, .presetn, .apb_req, .prdata, .pready, .pslverr, .rxd, .txd,
	.rs485_de, .rs485_re_n, .program_halt_switch
);
